// ==== rtl/cfg_byte_reg.sv ====
// One byte-wide configuration register with a per-bit write mask.
// Assumes the caller decodes the address and byte lane into wr_en.
`timescale 1ns/100ps
module cfg_byte_reg #(
    parameter logic [7:0] RST  = 8'h00,
    parameter logic [7:0] MASK = 8'hFF
) (
    // Clock, reset, enable
    input  wire  logic       clk,
    input  wire  logic       rst_b,
    input  wire  logic       ce,
    // Write port
    input  wire  logic       wr_en,
    input  wire  logic [7:0] wdata,
    // Stored value
    output logic       [7:0] q
);

    // Masked bits take write data, the rest hold their reset value
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            q <= RST;
        else if (ce && wr_en)
            q <= (q & ~MASK) | (wdata & MASK);
    end

endmodule

// ==== rtl/usb_function_config_header.sv ====
// Configuration header registers of the USB host controller function.
// Assumes config and I/O cycles are decoded by same-clock bus logic; the
// shared interrupt line arrives on a pin and is synchronised here.
`timescale 1ns/100ps
module usb_function_config_header
    import usb_cfg_pkg::*;
#(
    parameter logic [7:0] REV_ID   = REV_ID_DEFAULT,
    parameter logic [7:0] SPEC_REL = SPEC_REL_PRE
) (
    // Clock, reset, enable
    input  wire  logic        clk,
    input  wire  logic        rst_b,
    input  wire  logic        ce,
    // Configuration access
    input  wire  cfg_req_t    cfg_req,
    output logic              rd_valid_q,
    output logic       [31:0] rd_data_q,
    // I/O space decode
    input  wire  io_req_t     io_req,
    output logic              io_hit_q,
    // Interrupts
    input  wire  logic        usb_irq,
    input  wire  logic        pci_interrupt_line_d_b,
    output logic              pic_irq_q,
    // USB clock selection
    output logic              usb_clk_48_sel_q
);

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    logic        wr_cyc;
    logic        rd_cyc;
    logic        wr_base;
    logic        wr_il;
    logic        wr_misc;
    logic [7:0]  base_lo;
    logic [7:0]  base_hi;
    logic [7:0]  int_line;
    logic [7:0]  misc_lo;
    logic [7:0]  misc_hi;
    logic [31:0] rd_mux;
    logic [15:0] base_addr;
    logic        io_match;
    logic        pirq_s1_q;
    logic        pirq_s2_q;

    // Write strobes per register; read-only registers get none
    assign wr_cyc  = cfg_req.sel && cfg_req.wr;
    assign rd_cyc  = cfg_req.sel && !cfg_req.wr;
    assign wr_base = wr_cyc && (cfg_req.dw == IO_BASE_DW);
    assign wr_il   = wr_cyc && (cfg_req.dw == INT_LINE_DW);
    assign wr_misc = wr_cyc && (cfg_req.dw == MISC_DW);

    // ------------------------------------------------------------
    // Writable storage
    // ------------------------------------------------------------

    // Base field bits 15..5; low byte keeps only bits 7..5
    cfg_byte_reg #(
        .RST  (BYTE_RST),
        .MASK (BASE_LO_MASK)
    ) u_base_lo (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .wr_en (wr_base && cfg_req.be[0]),
        .wdata (cfg_req.wdata[7:0]),
        .q     (base_lo)
    );

    // Upper base byte, address bits 15..8
    cfg_byte_reg #(
        .RST  (BYTE_RST),
        .MASK (BYTE_ALL)
    ) u_base_hi (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .wr_en (wr_base && cfg_req.be[1]),
        .wdata (cfg_req.wdata[15:8]),
        .q     (base_hi)
    );

    // Interrupt line scratch, read back only, drives nothing
    cfg_byte_reg #(
        .RST  (BYTE_RST),
        .MASK (BYTE_ALL)
    ) u_int_line (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .wr_en (wr_il && cfg_req.be[0]),
        .wdata (cfg_req.wdata[7:0]),
        .q     (int_line)
    );

    // Misc register low byte, bit 0 is the clock select
    cfg_byte_reg #(
        .RST  (MISC_LO_RST),
        .MASK (BYTE_ALL)
    ) u_misc_lo (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .wr_en (wr_misc && cfg_req.be[2]),
        .wdata (cfg_req.wdata[23:16]),
        .q     (misc_lo)
    );

    // Misc register high byte
    cfg_byte_reg #(
        .RST  (MISC_HI_RST),
        .MASK (BYTE_ALL)
    ) u_misc_hi (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .wr_en (wr_misc && cfg_req.be[3]),
        .wdata (cfg_req.wdata[31:24]),
        .q     (misc_hi)
    );

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------

    // Hardwired fields fill the word, unmapped dwords read zero
    assign rd_mux =
        (cfg_req.dw == REV_ID_DW)      ? {24'h000000, REV_ID} :
        (cfg_req.dw == HEADER_TYPE_DW) ?
            {8'h00, HEADER_TYPE_VAL, 16'h0000} :
        (cfg_req.dw == IO_BASE_DW)     ?
            {16'h0000, base_hi, base_lo[7:5], 4'h0, 1'b1} :
        (cfg_req.dw == INT_LINE_DW)    ?
            {16'h0000, INT_PIN_VAL, int_line} :
        (cfg_req.dw == SPEC_REL_DW)    ? {24'h000000, SPEC_REL} :
        (cfg_req.dw == MISC_DW)        ? {misc_hi, misc_lo, 16'h0000} :
                                         32'h00000000;

    // Read answer one clock after the request is taken
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= 32'h00000000;
        end
        else if (ce)
        begin
            rd_valid_q <= rd_cyc;
            if (rd_cyc)
                rd_data_q <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // I/O window decode
    // ------------------------------------------------------------

    // 32-byte window; low five address bits are the register index
    assign base_addr = {base_hi, base_lo[7:5], 5'h00};
    assign io_match  = io_req.req &&
        (io_req.addr[BASE_MSB:BASE_LSB] ==
         base_addr[BASE_MSB:BASE_LSB]);

    // Claim flag registered for a clean output
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            io_hit_q <= 1'b0;
        else if (ce)
            io_hit_q <= io_match;
    end

    // ------------------------------------------------------------
    // Interrupt routing and clock select
    // ------------------------------------------------------------

    // Shared pin passes two flops before the OR
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pirq_s1_q <= 1'b1;
            pirq_s2_q <= 1'b1;
        end
        else if (ce)
        begin
            pirq_s1_q <= pci_interrupt_line_d_b;
            pirq_s2_q <= pirq_s1_q;
        end
    end

    // USB request merged with the shared line toward the PIC
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            pic_irq_q <= 1'b0;
        else if (ce)
            pic_irq_q <= usb_irq || !pirq_s2_q;
    end

    // Clock select follows misc bit 0, one means 48 MHz
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            usb_clk_48_sel_q <= MISC_LO_RST[CLK_SEL_BIT];
        else if (ce)
            usb_clk_48_sel_q <= misc_lo[CLK_SEL_BIT];
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Header type answers zero
    hdr_type_zero_a : assert property (
        (ce && rd_cyc && cfg_req.dw == HEADER_TYPE_DW)
        |=> (rd_valid_q && rd_data_q[23:16] == 8'h00))
        else $error("header type not zero");

    // Base read shows stored field in bits 15..5
    base_read_back_a : assert property (
        (ce && rd_cyc && cfg_req.dw == IO_BASE_DW)
        |=> (rd_data_q[15:5] == {$past(base_hi), $past(base_lo[7:5])}))
        else $error("base field read mismatch");

    // Upper half of base reads zero
    base_upper_zero_a : assert property (
        (ce && rd_cyc && cfg_req.dw == IO_BASE_DW)
        |=> (rd_data_q[31:16] == 16'h0000))
        else $error("base upper half not zero");

    // Space indicator and reserved bits of base
    base_low_bits_a : assert property (
        (ce && rd_cyc && cfg_req.dw == IO_BASE_DW)
        |=> (rd_data_q[4:0] == BASE_LOW_BITS))
        else $error("base bits 4..0 not 00001b");

    // A full base write lands in the field a cycle later
    base_write_a : assert property (
        (ce && wr_base && cfg_req.be[1:0] == 2'b11)
        |=> ({base_hi, base_lo} ==
             ($past(cfg_req.wdata[15:0]) & 16'hFFE0)))
        else $error("base write not stored");

    // Scratch writes leave the window and misc fields alone
    scratch_inert_a : assert property (
        (ce && wr_il)
        |=> $stable({base_addr, misc_hi, misc_lo}))
        else $error("scratch write disturbed a field");

    // Interrupt pin answers fourth line
    int_pin_code_a : assert property (
        (ce && rd_cyc && cfg_req.dw == INT_LINE_DW)
        |=> (rd_data_q[15:8] == INT_PIN_VAL))
        else $error("interrupt pin not 04h");

    // Merged interrupt follows the USB request directly and the shared line through the synchroniser
    irq_or_a : assert property (
        (ce && $past(ce) && $past(ce, 2) &&
         $past(rst_b) && $past(rst_b, 2))
        |-> (pic_irq_q == ($past(usb_irq) || !$past(pirq_s1_q, 2))))
        else $error("merged interrupt wrong");

    // Release number answers its code
    spec_rel_a : assert property (
        (ce && rd_cyc && cfg_req.dw == SPEC_REL_DW)
        |=> (rd_data_q[7:0] == SPEC_REL))
        else $error("release number wrong");

    // Clock select tracks misc bit 0
    clk_sel_a : assert property (
        ce |=> (usb_clk_48_sel_q == $past(misc_lo[CLK_SEL_BIT])))
        else $error("clock select stale");

    // Claim only inside the window
    io_window_a : assert property (
        (ce && io_req.req) |=> (io_hit_q ==
            ($past(io_req.addr[15:5]) == $past(base_addr[15:5]))))
        else $error("io claim wrong");

    // Revision ID stays hardwired
    rev_id_a : assert property (
        (ce && rd_cyc && cfg_req.dw == REV_ID_DW)
        |=> (rd_data_q == {24'h000000, REV_ID}))
        else $error("revision id changed");

endmodule

// ==== shared/usb_cfg_pkg.sv ====
// Shared constants and carriers for the USB function configuration header.
// Assumes a single 25 MHz clock shared by the config port and the block.
package usb_cfg_pkg;

    // ------------------------------------------------------------
    // Register byte offsets in configuration space
    // ------------------------------------------------------------
    localparam logic [7:0] REV_ID_OFS       = 8'h08;
    localparam logic [7:0] HEADER_TYPE_OFS  = 8'h0E;
    localparam logic [7:0] IO_BASE_OFS      = 8'h20;
    localparam logic [7:0] INT_LINE_OFS     = 8'h3C;
    localparam logic [7:0] INT_PIN_OFS      = 8'h3D;
    localparam logic [7:0] SPEC_REL_OFS     = 8'h60;
    localparam logic [7:0] MISC_OFS         = 8'h6A;

    // Dword index of each register (byte offset without the lane)
    localparam logic [5:0] REV_ID_DW        = REV_ID_OFS[7:2];
    localparam logic [5:0] HEADER_TYPE_DW   = HEADER_TYPE_OFS[7:2];
    localparam logic [5:0] IO_BASE_DW       = IO_BASE_OFS[7:2];
    localparam logic [5:0] INT_LINE_DW      = INT_LINE_OFS[7:2];
    localparam logic [5:0] SPEC_REL_DW      = SPEC_REL_OFS[7:2];
    localparam logic [5:0] MISC_DW          = MISC_OFS[7:2];

    // ------------------------------------------------------------
    // Field layout and fixed values
    // ------------------------------------------------------------
    localparam int         BASE_LSB         = 5;
    localparam int         BASE_MSB         = 15;
    localparam logic [7:0] BASE_LO_MASK     = 8'hE0;
    localparam logic [7:0] BYTE_ALL         = 8'hFF;
    localparam logic [4:0] BASE_LOW_BITS    = 5'h01;
    localparam logic [7:0] HEADER_TYPE_VAL  = 8'h00;
    localparam logic [7:0] INT_PIN_VAL      = 8'h04;
    localparam logic [7:0] SPEC_REL_PRE     = 8'h00;
    localparam logic [7:0] SPEC_REL_1_0     = 8'h10;
    localparam logic [7:0] REV_ID_DEFAULT   = 8'h00; // arbitrary value

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] BYTE_RST         = 8'h00;
    localparam logic [7:0] MISC_LO_RST      = 8'h01;
    localparam logic [7:0] MISC_HI_RST      = 8'h00;
    localparam int         CLK_SEL_BIT      = 0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        sel;   // Config cycle addressed to this function
        logic        wr;    // 1 write, 0 read
        logic [5:0]  dw;    // Dword index
        logic [3:0]  be;    // Byte enables, active high
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic        req;   // I/O cycle address phase
        logic [15:0] addr;
    } io_req_t;

endpackage

// ==== verification/cfg_host_model.sv ====
// Host model that issues configuration cycles to the function.
// Assumes the bench calls its task and owns the clock.
`timescale 1ns/100ps
module cfg_host_model
    import usb_cfg_pkg::*;
(
    // Clock
    input  wire  logic clk,
    // Request to the function
    output cfg_req_t   cfg_req
);
    // ------------------------------------
    // Access sequencing
    // ------------------------------------
    initial cfg_req = '0;

    // One access per call, changed just after the edge
    task automatic access(input logic wr, input logic [5:0] dw,
                          input logic [3:0] be, input logic [31:0] wd);
        @(posedge clk);
        #1;
        cfg_req = '{1'b1, wr, dw, be, wd};
        @(posedge clk);
        #1;
        // Idle lines carry no stale copy of the last access
        cfg_req = '{1'b0, 1'b0, ~dw, 4'h0, ~wd};
    endtask
endmodule

// ==== verification/usb_function_config_header_bench.sv ====
// Self-checking bench for the USB function configuration header.
// Assumes the host model drives config cycles; the bench drives the rest.
`timescale 1ns/100ps
module usb_function_config_header_bench
    import usb_cfg_pkg::*;
;
    logic        clk;
    logic        rst_b;
    logic        ce;
    logic        rd_valid_q;
    logic        io_hit_q;
    logic        usb_irq;
    logic        line_b;
    logic        pic_irq_q;
    logic        usb_clk_48_sel_q;
    logic [31:0] rd_data_q;
    logic [31:0] w;
    logic [63:0] notes[$];
    logic [63:0] note;
    cfg_req_t    cfg_req;
    io_req_t     io_req;
    int          n_errors;
    int          comparisons;

    cfg_host_model HOST (.clk(clk), .cfg_req(cfg_req));

    usb_function_config_header #(.SPEC_REL(SPEC_REL_1_0)) DUT (
        .clk(clk), .rst_b(rst_b), .ce(ce), .cfg_req(cfg_req),
        .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
        .io_req(io_req), .io_hit_q(io_hit_q), .usb_irq(usb_irq),
        .pci_interrupt_line_d_b(line_b), .pic_irq_q(pic_irq_q),
        .usb_clk_48_sel_q(usb_clk_48_sel_q));

    // ------------------------------------
    // Checking helpers
    // ------------------------------------
    task automatic check(input logic [31:0] got, exp, msk);
        comparisons++;
        if ((got & msk) !== (exp & msk))
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Note the expected lanes, then read
    task automatic rd(input logic [5:0] dw, input logic [31:0] e, m);
        notes.push_back({e, m});
        HOST.access(1'b0, dw, 4'hF, 32'h0);
    endtask

    // One I/O address phase, hit seen in the next cycle
    task automatic io(input logic [15:0] a, input logic hit);
        @(posedge clk);
        #1;
        io_req = '{1'b1, a};
        @(posedge clk);
        #1;
        io_req = '{1'b0, ~a};
        check({31'h0, io_hit_q}, {31'h0, hit}, 32'h1);
    endtask

    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Compare each read answer with the oldest note
    always @(negedge clk)
        if (rd_valid_q === 1'b1)
        begin
            if (notes.size() == 0)
                check(rd_data_q, ~rd_data_q, 32'hFFFFFFFF);
            else
            begin
                note = notes.pop_front();
                check(rd_data_q, note[63:32], note[31:0]);
            end
        end

    // Watchdog
    initial
    begin
        #(40 * 4000);
        n_errors++;
        final_report();
    end

    // ------------------------------------
    // Main sequence
    // ------------------------------------
    initial
    begin
        {rst_b, usb_irq, n_errors, comparisons} = '0;
        {ce, line_b} = 2'b11;
        io_req = '0;
        void'($urandom(14));
        repeat (6) @(posedge clk);
        #1;
        rst_b = 1'b1;
        check({31'h0, usb_clk_48_sel_q}, 32'h1, 32'h1);
        // Fixed registers, also after writes of all ones
        repeat (2)
        begin
            rd(6'h03, 32'h0, 32'h00FF0000);
            rd(6'h0F, 32'h0400, 32'hFF00);
            rd(6'h18, 32'h10, 32'hFF);
            rd(6'h02, {24'h0, REV_ID_DEFAULT}, 32'hFF);
            HOST.access(1'b1, 6'h03, 4'hF, 32'hFFFFFFFF);
            HOST.access(1'b1, 6'h0F, 4'h2, 32'hFFFFFFFF);
            HOST.access(1'b1, 6'h18, 4'hF, 32'hFFFFFFFF);
            HOST.access(1'b1, 6'h02, 4'hF, 32'hFFFFFFFF);
        end
        rd(6'h08, 32'h1, 32'hFFFFFFFF);
        rd(6'h1A, 32'h00010000, 32'hFFFF0000);
        // Base field, low bits fixed, upper half written as zeros
        repeat (4)
        begin
            w = $urandom;
            HOST.access(1'b1, 6'h08, 4'hF, {16'h0, w[15:0]});
            rd(6'h08, {16'h0, w[15:5], 5'h01}, 32'hFFFFFFFF);
            io({w[15:5], 5'h1F}, 1'b1);
            io({w[15:5], 5'h00}, 1'b1);
            io({w[15:6], ~w[5], 5'h00}, 1'b0);
            io({~w[15], w[14:5], 5'h10}, 1'b0);
        end
        // Scratch byte stores and has no side effect
        HOST.access(1'b1, 6'h0F, 4'h1, {24'h0, w[31:24]});
        rd(6'h0F, {16'h0, 8'h04, w[31:24]}, 32'hFFFF);
        check({31'h0, pic_irq_q}, 32'h0, 32'h1);
        io({w[15:5], 5'h03}, 1'b1);
        // Enable low freezes state: write ignored, claim flag held
        ce = 1'b0;
        HOST.access(1'b1, 6'h08, 4'hF, {16'h0, ~w[15:0]});
        check({31'h0, io_hit_q}, 32'h1, 32'h1);
        ce = 1'b1;
        rd(6'h08, {16'h0, w[15:5], 5'h01}, 32'hFFFFFFFF);
        // Clock selection both ways
        HOST.access(1'b1, 6'h1A, 4'hC, 32'hABCE0000);
        rd(6'h1A, 32'hABCE0000, 32'hFFFF0000);
        check({31'h0, usb_clk_48_sel_q}, 32'h0, 32'h1);
        HOST.access(1'b1, 6'h1A, 4'h4, 32'h00010000);
        rd(6'h1A, 32'hAB010000, 32'hFFFF0000);
        check({31'h0, usb_clk_48_sel_q}, 32'h1, 32'h1);
        // Mid-run reset restores the stored fields
        rst_b = 1'b0;
        @(posedge clk);
        #1;
        rst_b = 1'b1;
        rd(6'h08, 32'h1, 32'hFFFFFFFF);
        rd(6'h1A, 32'h00010000, 32'hFFFF0000);
        // Controller interrupt ORed with the shared line
        usb_irq = 1'b1;
        @(posedge clk);
        #1;
        check({31'h0, pic_irq_q}, 32'h1, 32'h1);
        usb_irq = 1'b0;
        @(posedge clk);
        #1;
        check({31'h0, pic_irq_q}, 32'h0, 32'h1);
        line_b = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check({31'h0, pic_irq_q}, 32'h1, 32'h1);
        usb_irq = 1'b1;
        line_b = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check({31'h0, pic_irq_q}, 32'h1, 32'h1);
        usb_irq = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({31'h0, pic_irq_q}, 32'h0, 32'h1);
        check(notes.size(), 32'h0, 32'hFFFFFFFF);
        final_report();
    end
endmodule
